// ---- design/mgs_defs.svh ----
// constants of the management register bank slice: offsets, resets, field positions
// assumes inclusion by bare name from the package and the design modules
//
// Functional notes
// - clock observe output driven only while enable set
// - latched-low bit reads zero while condition present
// - latched-low bit holds zero until next read
// - latched-low reads one only if not occurred since last read
// - latched-high bit reads one while condition present
// - latched-high bit holds one until next read
// - latched-high reads zero only if not occurred since last read
// - second read separates past from persisting condition
// - clear-on-read counter zeroes when read
`ifndef MGS_DEFS_SVH
`define MGS_DEFS_SVH

// ------------------------------------------------------------------
// widths
// ------------------------------------------------------------------
`define MGS_DATA_W 16
`define MGS_ADDR_W 16

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define MGS_OFS_RSVD_CTRL_A 16'h0015
`define MGS_OFS_RSVD_CTRL_B 16'h0016
`define MGS_OFS_RSVD_CTRL_C 16'h0017
`define MGS_OFS_RSVD_STAT_A 16'h0018
`define MGS_OFS_RSVD_CTRL_D 16'h0019
`define MGS_OFS_RSVD_CTRL_E 16'h001a
`define MGS_OFS_RSVD_STAT_B 16'h001b
`define MGS_OFS_CLK_OBS_CTRL 16'h001c
`define MGS_OFS_RSVD_STAT_C 16'h001d
`define MGS_OFS_RSVD_CTRL_F 16'h001e
`define MGS_OFS_RSVD_CTRL_G 16'h001f
`define MGS_OFS_RSVD_STAT_D 16'h8000
`define MGS_OFS_RSVD_STAT_E 16'h8001
`define MGS_OFS_RSVD_STAT_F 16'h8002
`define MGS_OFS_RSVD_STAT_G 16'h8003
`define MGS_OFS_RSVD_STAT_H 16'h8004
`define MGS_OFS_RSVD_STAT_I 16'h8005
`define MGS_OFS_RSVD_STAT_J 16'h8006
`define MGS_OFS_RSVD_STAT_K 16'h8007
`define MGS_OFS_LATCHED_LOW 16'h8008
`define MGS_OFS_LATCHED_HIGH 16'h8009
`define MGS_OFS_EVENT_COUNT 16'h800a

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define MGS_RST_RSVD_CTRL_A 16'h0023
`define MGS_RST_RSVD_CTRL_B 16'h0023
`define MGS_RST_RSVD_CTRL_C 16'h0008
`define MGS_RST_RSVD_STAT_A 16'h0000
`define MGS_RST_RSVD_CTRL_D 16'h0000
`define MGS_RST_RSVD_CTRL_E 16'h0000
`define MGS_RST_RSVD_STAT_B 16'h0000
`define MGS_RST_CLK_OBS_CTRL 16'h0001
`define MGS_RST_RSVD_STAT_C 16'h0200
`define MGS_RST_RSVD_CTRL_F 16'h0000
`define MGS_RST_RSVD_CTRL_G 16'h0000
`define MGS_RST_RSVD_STAT_HI 16'h0000
`define MGS_RST_ZERO 16'h0000
`define MGS_UNMAPPED_DATA 16'h0000

// ------------------------------------------------------------------
// fields
// ------------------------------------------------------------------
`define MGS_CLK_OBS_EN_BIT 14
`define MGS_CLK_OBS_EN_RST 1'b0
`define MGS_CNT_MAX 16'hffff
`define MGS_CNT_ONE 16'h0001

`endif

// ---- design/mgs_pkg.sv ----
// types shared by the management register bank slice
// assumes mgs_defs.svh is on the include path
`include "mgs_defs.svh"

package mgs_pkg;

  // ------------------------------------------------------------------
  // data and address types
  // ------------------------------------------------------------------
  typedef logic [`MGS_DATA_W-1:0] mgs_word_t;
  typedef logic [`MGS_ADDR_W-1:0] mgs_addr_t;

endpackage

// ---- design/mgs_lat_if.sv ----
// carrier between the register bank and one latched status bank
// assumes both ends run on the bank's single clock
interface mgs_lat_if;
  import mgs_pkg::*;

  mgs_word_t cond;
  logic rd;
  mgs_word_t value;

  // ------------------------------------------------------------------
  // the bank holds the sticky state, the user feeds conditions
  // ------------------------------------------------------------------
  modport bank (
    input cond,
    input rd,
    output value
  );
  modport user (
    output cond,
    output rd,
    input value
  );
endinterface

// ---- design/mgs_latch_bank.sv ----
// sixteen latched status bits of one polarity
// assumes rd is a one-cycle pulse on the cycle a read is taken
`include "mgs_defs.svh"

module mgs_latch_bank #(
  parameter bit ACTIVE_HIGH = 1'b1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  mgs_lat_if.bank lat
);
  import mgs_pkg::*;

  mgs_word_t seen_q;
  mgs_word_t seen_d;
  mgs_word_t live;

  // ------------------------------------------------------------------
  // sticky memory of past conditions
  // ------------------------------------------------------------------
  // a condition present in the read cycle wins over the clear
  always_comb begin
    seen_d = lat.rd ? lat.cond : (seen_q | lat.cond);
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      seen_q <= `MGS_RST_ZERO;
    end else begin
      seen_q <= seen_d;
    end
  end

  // ------------------------------------------------------------------
  // read value: present now or seen since the last read
  // ------------------------------------------------------------------
  assign live = lat.cond | seen_q;
  // latched-low inverts, so an absent and unseen condition reads one
  assign lat.value = ACTIVE_HIGH ? live : ~live;

endmodule

// ---- design/mgs_regbank.sv ----
// management register bank slice: reserved registers, clock observe control,
// latched-low, latched-high and clear-on-read status
// assumes the management host issues one-cycle requests synchronous to clk_i
`include "mgs_defs.svh"

module mgs_regbank (
  input wire logic clk_i,
  input wire logic reset_i,
  // management access port
  input wire logic mgmt_req_i,
  input wire logic mgmt_we_i,
  input wire mgs_pkg::mgs_addr_t mgmt_addr_i,
  input wire mgs_pkg::mgs_word_t mgmt_wdata_i,
  output logic mgmt_ack_o,
  output mgs_pkg::mgs_word_t mgmt_rdata_o,
  // monitored conditions and counted events
  input wire mgs_pkg::mgs_word_t ll_cond_i,
  input wire mgs_pkg::mgs_word_t lh_cond_i,
  input wire logic count_event_i,
  // clock observation
  input wire logic obs_clk_src_i,
  output logic clock_observe_enable_o,
  output logic clk_obs_p_o,
  output logic clk_obs_n_o,
  output logic clk_obs_oe_o
);
  import mgs_pkg::*;

  logic rd_stb;
  logic wr_stb;
  logic obs_en_q;
  mgs_word_t cnt_q;
  mgs_word_t cnt_d;
  mgs_word_t rdata_d;
  mgs_word_t obs_ctrl_rd;

  mgs_lat_if ll_if ();
  mgs_lat_if lh_if ();

  // ------------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------------
  assign rd_stb = mgmt_req_i & ~mgmt_we_i;
  assign wr_stb = mgmt_req_i & mgmt_we_i;

  // ------------------------------------------------------------------
  // latched status banks
  // ------------------------------------------------------------------
  assign ll_if.cond = ll_cond_i;
  assign ll_if.rd = rd_stb && (mgmt_addr_i == `MGS_OFS_LATCHED_LOW);
  assign lh_if.cond = lh_cond_i;
  assign lh_if.rd = rd_stb && (mgmt_addr_i == `MGS_OFS_LATCHED_HIGH);

  mgs_latch_bank #(
    .ACTIVE_HIGH(1'b0)
  ) u_latched_low (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .lat(ll_if.bank)
  );

  mgs_latch_bank #(
    .ACTIVE_HIGH(1'b1)
  ) u_latched_high (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .lat(lh_if.bank)
  );

  // ------------------------------------------------------------------
  // clear-on-read event counter
  // ------------------------------------------------------------------
  // saturates rather than wraps so a busy link never reads as quiet;
  // an event in the read cycle is kept as the first count afterwards
  always_comb begin
    if (rd_stb && (mgmt_addr_i == `MGS_OFS_EVENT_COUNT)) begin
      cnt_d = count_event_i ? `MGS_CNT_ONE : `MGS_RST_ZERO;
    end else if (count_event_i && (cnt_q != `MGS_CNT_MAX)) begin
      cnt_d = mgs_word_t'(cnt_q + `MGS_CNT_ONE); // saturation above keeps the carry unused
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= `MGS_RST_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ------------------------------------------------------------------
  // clock observe control
  // ------------------------------------------------------------------
  // only the enable bit is stored; the other bits keep their defaults
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      obs_en_q <= `MGS_CLK_OBS_EN_RST;
    end else if (wr_stb && (mgmt_addr_i == `MGS_OFS_CLK_OBS_CTRL)) begin
      obs_en_q <= mgmt_wdata_i[`MGS_CLK_OBS_EN_BIT];
    end
  end

  always_comb begin
    obs_ctrl_rd = `MGS_RST_CLK_OBS_CTRL;
    obs_ctrl_rd[`MGS_CLK_OBS_EN_BIT] = obs_en_q;
  end

  assign clock_observe_enable_o = obs_en_q;

  // ------------------------------------------------------------------
  // differential observation driver
  // ------------------------------------------------------------------
  // registered so the pair changes together; both legs rest low when off
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      clk_obs_p_o <= 1'b0;
      clk_obs_n_o <= 1'b0;
      clk_obs_oe_o <= 1'b0;
    end else begin
      clk_obs_p_o <= obs_en_q & obs_clk_src_i;
      clk_obs_n_o <= obs_en_q & ~obs_clk_src_i;
      clk_obs_oe_o <= obs_en_q;
    end
  end

  // ------------------------------------------------------------------
  // read multiplexer
  // ------------------------------------------------------------------
  // reserved registers hold no storage: writes vanish, reads give defaults
  always_comb begin
    unique case (mgmt_addr_i)
      `MGS_OFS_RSVD_CTRL_A: rdata_d = `MGS_RST_RSVD_CTRL_A;
      `MGS_OFS_RSVD_CTRL_B: rdata_d = `MGS_RST_RSVD_CTRL_B;
      `MGS_OFS_RSVD_CTRL_C: rdata_d = `MGS_RST_RSVD_CTRL_C;
      `MGS_OFS_RSVD_STAT_A: rdata_d = `MGS_RST_RSVD_STAT_A;
      `MGS_OFS_RSVD_CTRL_D: rdata_d = `MGS_RST_RSVD_CTRL_D;
      `MGS_OFS_RSVD_CTRL_E: rdata_d = `MGS_RST_RSVD_CTRL_E;
      `MGS_OFS_RSVD_STAT_B: rdata_d = `MGS_RST_RSVD_STAT_B;
      `MGS_OFS_CLK_OBS_CTRL: rdata_d = obs_ctrl_rd;
      `MGS_OFS_RSVD_STAT_C: rdata_d = `MGS_RST_RSVD_STAT_C;
      `MGS_OFS_RSVD_CTRL_F: rdata_d = `MGS_RST_RSVD_CTRL_F;
      `MGS_OFS_RSVD_CTRL_G: rdata_d = `MGS_RST_RSVD_CTRL_G;
      `MGS_OFS_RSVD_STAT_D,
      `MGS_OFS_RSVD_STAT_E,
      `MGS_OFS_RSVD_STAT_F,
      `MGS_OFS_RSVD_STAT_G,
      `MGS_OFS_RSVD_STAT_H,
      `MGS_OFS_RSVD_STAT_I,
      `MGS_OFS_RSVD_STAT_J,
      `MGS_OFS_RSVD_STAT_K: rdata_d = `MGS_RST_RSVD_STAT_HI;
      `MGS_OFS_LATCHED_LOW: rdata_d = ll_if.value;
      `MGS_OFS_LATCHED_HIGH: rdata_d = lh_if.value;
      `MGS_OFS_EVENT_COUNT: rdata_d = cnt_q;
      default: rdata_d = `MGS_UNMAPPED_DATA;
    endcase
  end

  // ------------------------------------------------------------------
  // answer register
  // ------------------------------------------------------------------
  // read data is captured in the taking cycle, so the clear that follows
  // the read can never corrupt the value returned
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mgmt_rdata_o <= `MGS_RST_ZERO;
    end else if (rd_stb) begin
      mgmt_rdata_o <= rdata_d;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mgmt_ack_o <= 1'b0;
    end else begin
      mgmt_ack_o <= mgmt_req_i;
    end
  end

endmodule

// ---- test/mgs_host_model.sv ----
// management host model: one-cycle requests, reads answered through ack
// assumes the bank acks one cycle after each taken request
module mgs_host_model (
  input wire logic clk_i,
  input wire logic ack_i,
  output logic req_o,
  output logic we_o,
  output mgs_pkg::mgs_addr_t addr_o,
  output mgs_pkg::mgs_word_t wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import mgs_pkg::*;
  // ------------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------------
  initial begin
    req_o = 1'b0;
    we_o = 1'b0;
    addr_o = 16'h0000;
    wdata_o = 16'h0000;
  end
  // request lives one edge only, a longer strobe would be taken twice
  task automatic xfer(logic w, mgs_addr_t a, mgs_word_t d);
    @(negedge clk_i);
    req_o = 1'b1;
    we_o = w;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    req_o = 1'b0;
    we_o = ~w; // released lines show the inverse, not a stale value
    addr_o = ~a;
    wdata_o = ~d;
    for (int i = 0; i < 4 && ack_i !== 1'b1; i++) @(negedge clk_i);
  endtask
  // a status word is read twice to tell a past event from a live one
  task automatic reread(mgs_addr_t a);
    xfer(1'b0, a, 16'h0000);
    xfer(1'b0, a, 16'h0000);
  endtask
endmodule

// ---- test/mgs_regbank_asserts.sv ----
// timing and read-value checks on the register bank slice
// assumes it is bound to mgs_regbank and sees only its ports
module mgs_regbank_asserts (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic mgmt_req_i,
  input wire logic mgmt_we_i,
  input wire mgs_pkg::mgs_addr_t mgmt_addr_i,
  input wire mgs_pkg::mgs_word_t mgmt_wdata_i,
  input wire logic mgmt_ack_o,
  input wire mgs_pkg::mgs_word_t mgmt_rdata_o,
  input wire mgs_pkg::mgs_word_t ll_cond_i,
  input wire mgs_pkg::mgs_word_t lh_cond_i,
  input wire logic count_event_i,
  input wire logic obs_clk_src_i,
  input wire logic clock_observe_enable_o,
  input wire logic clk_obs_p_o,
  input wire logic clk_obs_n_o,
  input wire logic clk_obs_oe_o
);
  import mgs_pkg::*;
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // decoded request kinds
  wire logic rdx = mgmt_req_i && !mgmt_we_i;
  wire logic wr1c = mgmt_req_i && mgmt_we_i && mgmt_addr_i == 16'h001c;
  wire logic rdc = rdx && mgmt_addr_i == 16'h800a && !count_event_i;
  wire logic en = clock_observe_enable_o;
  property p_ack; mgmt_req_i |=> mgmt_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_en_wr; wr1c |=> en == $past(mgmt_wdata_i[14]); endproperty
  a_en_wr: assert property (p_en_wr) else $error("enable not written");
  property p_en_hold; $changed(en) |-> $past(wr1c); endproperty
  a_en_hold: assert property (p_en_hold) else $error("enable moved alone");
  property p_legs; 1'b1 |=> {clk_obs_oe_o, clk_obs_p_o, clk_obs_n_o} ==
    {$past(en), $past(en) & $past(obs_clk_src_i), $past(en) & !$past(obs_clk_src_i)}; endproperty
  a_legs: assert property (p_legs) else $error("observe pair wrong");
  property p_rd1c; rdx && mgmt_addr_i == 16'h001c |=>
    mgmt_rdata_o == (16'h0001 | {1'b0, $past(en), 14'h0000}); endproperty
  a_rd1c: assert property (p_rd1c) else $error("observe control read wrong");
  property p_rsvd; rdx && mgmt_addr_i == 16'h001d |=> mgmt_rdata_o == 16'h0200; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read wrong");
  property p_ll; rdx && mgmt_addr_i == 16'h8008 |=>
    (mgmt_rdata_o & $past(ll_cond_i)) == 16'h0000; endproperty
  a_ll: assert property (p_ll) else $error("live low condition read one");
  property p_lh; rdx && mgmt_addr_i == 16'h8009 |=>
    (mgmt_rdata_o & $past(lh_cond_i)) == $past(lh_cond_i); endproperty
  a_lh: assert property (p_lh) else $error("live high condition read zero");
  property p_cor; rdc ##1 !count_event_i ##1 rdc |=> mgmt_rdata_o == 16'h0000; endproperty
  a_cor: assert property (p_cor) else $error("counter not cleared by read");
  c_wr1c: cover property (wr1c);
  c_ll: cover property (rdx && mgmt_addr_i == 16'h8008 && ll_cond_i != 16'h0000);
  c_cor: cover property (rdc ##1 !count_event_i ##1 rdc);
endmodule
bind mgs_regbank mgs_regbank_asserts u_mgs_regbank_asserts (.*);

// ---- test/tb.sv ----
// self-checking bench for the register bank slice, host model on the access port
// assumes the design, package and host model are compiled before it
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mgs_pkg::*;
  // ------------------------------------------------------------------
  // stimulus, scoreboard and closing
  // ------------------------------------------------------------------
  logic clk_i = 1'b0, reset_i = 1'b1, ev = 1'b0, src = 1'b0, tkn_we = 1'b1;
  logic req, we, ack, en, p, n, oe;
  mgs_addr_t addr;
  mgs_word_t wdata, rdata, c, ll = 16'h0000, lh = 16'h0000;
  mgs_word_t expq[$];
  int miscompares = 0, check_count = 0, k;
  mgs_regbank u_mgs_regbank (.clk_i(clk_i), .reset_i(reset_i), .mgmt_req_i(req),
    .mgmt_we_i(we), .mgmt_addr_i(addr), .mgmt_wdata_i(wdata), .mgmt_ack_o(ack),
    .mgmt_rdata_o(rdata), .ll_cond_i(ll), .lh_cond_i(lh), .count_event_i(ev),
    .obs_clk_src_i(src), .clock_observe_enable_o(en), .clk_obs_p_o(p),
    .clk_obs_n_o(n), .clk_obs_oe_o(oe));
  mgs_host_model u_mgs_host_model (.clk_i(clk_i), .ack_i(ack), .req_o(req), .we_o(we),
    .addr_o(addr), .wdata_o(wdata));
  // clock and an observed source that toggles every cycle
  initial forever #5 clk_i = ~clk_i;
  always @(negedge clk_i) src <= ~src;
  task automatic chk(string nm, mgs_word_t seen, mgs_word_t exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(mgs_addr_t a, mgs_word_t e);
    expq.push_back(e);
    u_mgs_host_model.xfer(1'b0, a, 16'h0000);
  endtask
  task automatic rd2(mgs_addr_t a, mgs_word_t e1, mgs_word_t e2);
    expq.push_back(e1);
    expq.push_back(e2);
    u_mgs_host_model.reread(a);
  endtask
  function automatic mgs_addr_t ra(int i);
    return 16'(i < 11 ? 'h15 + i : 'h7ff5 + i);
  endfunction
  function automatic mgs_word_t rv(int i);
    case (i)
      0, 1: return 16'h0023;
      2: return 16'h0008;
      8: return 16'h0200;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // read data is judged in the cycle ack stands, writes are skipped
  always @(posedge clk_i) if (req === 1'b1) tkn_we <= we;
  always @(negedge clk_i) begin
    if (ack === 1'b1 && tkn_we === 1'b0) chk("rdata", rdata, expq.pop_front());
  end
  // a hang costs one mismatch and still reaches the verdict
  initial begin
    #20us;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(88012));
    repeat (6) @(posedge clk_i);
    @(negedge clk_i) reset_i = 1'b0;
    for (int i = 0; i < 19; i++) if (i != 7) begin
      c = $urandom;
      rd(ra(i), rv(i));
      u_mgs_host_model.xfer(1'b1, ra(i), c);
      rd(ra(i), rv(i));
    end
    rd(16'h0020, 16'h0000);
    $display("reserved test done");
    rd(16'h001c, 16'h0001);
    u_mgs_host_model.xfer(1'b1, 16'h001c, c | 16'h4000);
    rd(16'h001c, 16'h4001);
    chk("oe", 16'(oe), 16'h0001);
    chk("en", 16'(en), 16'h0001);
    // src still holds the value taken at the last rising edge here
    chk("legs", 16'({p, n}), 16'({src, ~src}));
    u_mgs_host_model.xfer(1'b1, 16'h001c, c & 16'hbfff);
    rd(16'h001c, 16'h0001);
    chk("oe", 16'(oe), 16'h0000);
    chk("en", 16'(en), 16'h0000);
    chk("legs", 16'({p, n}), 16'h0000);
    $display("observe test done");
    c = $urandom | 16'h0001;
    @(negedge clk_i);
    ll = c;
    lh = c;
    @(negedge clk_i);
    ll = 16'h0000;
    lh = 16'h0000;
    rd2(16'h8008, ~c, 16'hffff);
    rd2(16'h8009, c, 16'h0000);
    c = $urandom | 16'h8000;
    ll = c;
    lh = c;
    rd2(16'h8008, ~c, ~c);
    rd2(16'h8009, c, c);
    ll = 16'h0000;
    lh = 16'h0000;
    $display("latched test done");
    k = $urandom_range(20, 1);
    ev = 1'b1;
    repeat (k) @(negedge clk_i);
    ev = 1'b0;
    rd2(16'h800a, 16'(k), 16'h0000);
    $display("counter test done");
    // let the compare process pop the last note before the queue is judged
    @(posedge clk_i);
    chk("queue", 16'(expq.size()), 16'h0000);
    tally_and_finish();
  end
endmodule
